// ===== design/ior_count_mem.v
// Fire count memory: one write port, two read ports with registered read data
`timescale 1ns/1ps
`default_nettype none
module ior_count_mem #(
  parameter W = 32,
  parameter D = 12,
  parameter AW = 4
) (
  input wire clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [W-1:0] wr_data,
  input wire [AW-1:0] rd_a_addr,
  output reg [W-1:0] rd_a_data,
  input wire [AW-1:0] rd_b_addr,
  output reg [W-1:0] rd_b_data
);
  reg [W-1:0] mem [0:D-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_a_data <= mem[rd_a_addr];
    rd_b_data <= mem[rd_b_addr];
  end
endmodule // ior_count_mem
`default_nettype wire

// ===== design/ior_defs.vh
// Register offsets, field layouts, reset values and encodings of the interrupt output routing block
`ifndef IOR_DEFS_VH
`define IOR_DEFS_VH

`define IOR_LINES 12
`define IOR_TIMERS 8

`define IOR_OFS_STATE 8'h00
`define IOR_OFS_PEND 8'h04
`define IOR_OFS_ERR 8'h08
`define IOR_OFS_REQ 8'h0C
`define IOR_OFS_SET 8'h10
`define IOR_OFS_ARM 8'h14
`define IOR_OFS_EN 8'h18
`define IOR_OFS_CLR 8'h20
`define IOR_OFS_DIR 8'h24
`define IOR_OFS_TERM 8'h28
`define IOR_REGION_OUT 2'h1
`define IOR_REGION_DI 2'h2
`define IOR_REGION_CNT 2'h3

`define IOR_KIND_NONE 4'h0
`define IOR_KIND_RTC 4'h1
`define IOR_KIND_PIG 4'h2
`define IOR_KIND_INPUT 4'h3
`define IOR_KIND_DI 4'h4
`define IOR_KIND_GPS 4'h5
`define IOR_KIND_IRIG 4'h6
`define IOR_KIND_CLK10 4'h7
`define IOR_KIND_MTIME 4'h8

`define IOR_SEL_IDX 3:0
`define IOR_SEL_KIND 7:4
`define IOR_CFG_MODE 9:8

`define IOR_MODE_RISE 2'h0
`define IOR_MODE_FALL 2'h1
`define IOR_MODE_HIGH 2'h2
`define IOR_MODE_LOW 2'h3

`define IOR_RST_DIR 12'h03F
`define IOR_RST_TERM 12'h000
`define IOR_RST_CFG 10'h100

`endif

// ===== design/ior_routing.v
// Interrupt output routing: output line sources, software pulse generators, chain interrupt lines
// What this block does
// - Twelve external output lines, numbered zero to eleven, for machines or equipment.
// - Each output line driven by one chosen source; none leaves it floating.
// - After reset output line n selects pulse generator bit n; only output pins 0-5 drive it.
// - Bidirectional variant refuses a pin's own input as its own output source.
// - A pin sources only as input, and is driven only as output.
// - Each bidirectional pin has its own direction and termination setting.
// - After reset pins 0-5 output, 6-11 input, none terminated.
// - Pulse generator state register is twelve bits, one per generator.
// - Set register at 0x10 sets generator bits without read-modify-write.
// - Clear register at 0x20 clears generator bits without read-modify-write.
// - A set generator bit asserts every line that selects it as source, except a bidirectional pin set as input.
// - Twelve pulse generators, numbered zero to eleven.
// - Twelve chain interrupt lines reaching every board together.
// - Each chain line driven by one chosen source; none means not driven.
// - After reset no chain line has a source.
// - Each chain line triggers on rising, falling, high or low.
// - Chain interrupt reaches the host only when armed and enabled.
// - Software may request a chain interrupt without any source event.
// - A readable fire count is kept for each chain line.
// - All boards on the chain use compatible source and trigger settings.
`timescale 1ns/1ps
`default_nettype none
`include "ior_defs.vh"
module ior_routing #(
  parameter LINES = 12,
  parameter BIDIR = 1,
  parameter CNT_W = 32
) (
  input wire ref_clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [31:0] reg_wdata,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output reg reg_rvalid,
  input wire [`IOR_TIMERS-1:0] rtc_tick,
  input wire gps_pulse,
  input wire irig_signal,
  input wire clk10_signal,
  input wire master_time,
  input wire [LINES-1:0] bidirectional_ext_pin_in,
  output reg [LINES-1:0] external_output_line_out,
  output reg [LINES-1:0] external_output_line_oe,
  output wire [LINES-1:0] pin_terminate,
  input wire [LINES-1:0] chain_interrupt_line_in,
  output reg [LINES-1:0] chain_interrupt_line_out,
  output reg [LINES-1:0] chain_interrupt_line_oe,
  output wire [LINES-1:0] host_irq
);
  localparam ST_INIT = 2'd0;
  localparam ST_IDLE = 2'd1;
  localparam ST_READ = 2'd2;
  localparam ST_WRITE = 2'd3;

  reg [LINES-1:0] pulse_gen_state;
  reg [LINES-1:0] pin_dir;
  reg [LINES-1:0] pin_term;
  reg [LINES-1:0] di_arm;
  reg [LINES-1:0] di_en;
  reg [LINES-1:0] di_pend;
  reg [LINES-1:0] di_prev;
  reg [LINES-1:0] fire_todo;
  reg err_invalid;
  reg [7:0] out_sel [0:LINES-1];
  reg [9:0] di_cfg [0:LINES-1];
  reg [1:0] cnt_state;
  reg [3:0] cnt_idx;
  reg [3:0] rd_idx;
  reg [7:0] rd_addr_q;
  reg rd_q;
  reg [31:0] next_rdata;
  reg [CNT_W-1:0] mem_wdata;
  reg mem_we;
  reg [3:0] next_pick;
  integer j;
  integer k;

  wire [CNT_W-1:0] cnt_rdata;
  wire [CNT_W-1:0] sw_rdata;
  wire [3:0] wr_idx = reg_addr[5:2];
  wire idx_ok = (wr_idx < LINES);
  wire [LINES-1:0] src_inputs;
  wire [LINES-1:0] di_fire;
  wire [LINES-1:0] req_hit;
  wire [LINES-1:0] pend_clr = (reg_wr && reg_addr == `IOR_OFS_PEND) ? reg_wdata[LINES-1:0] : {LINES{1'b0}};

  // Source validity; the chain lines accept a narrower set of kinds
  function sel_ok;
    input [7:0] sel;
    input for_di;
    input [3:0] own;
    begin
      case (sel[`IOR_SEL_KIND])
        `IOR_KIND_NONE, `IOR_KIND_GPS, `IOR_KIND_IRIG: sel_ok = 1'b1;
        `IOR_KIND_RTC: sel_ok = (sel[`IOR_SEL_IDX] < `IOR_TIMERS);
        `IOR_KIND_PIG: sel_ok = (sel[`IOR_SEL_IDX] < LINES);
        `IOR_KIND_INPUT: sel_ok = (sel[`IOR_SEL_IDX] < LINES) && (for_di || BIDIR == 0 || sel[`IOR_SEL_IDX] != own);
        `IOR_KIND_DI: sel_ok = !for_di && (sel[`IOR_SEL_IDX] < LINES);
        `IOR_KIND_CLK10, `IOR_KIND_MTIME: sel_ok = !for_di;
        default: sel_ok = 1'b0;
      endcase
    end
  endfunction

  // Value of a chosen source, shared by output lines and chain lines
  function src_val;
    input [7:0] sel;
    input [`IOR_TIMERS-1:0] rtc;
    input [LINES-1:0] pig;
    input [LINES-1:0] inp;
    input [LINES-1:0] di;
    input [3:0] misc;
    begin
      case (sel[`IOR_SEL_KIND])
        `IOR_KIND_RTC: src_val = rtc[sel[2:0]];
        `IOR_KIND_PIG: src_val = pig[sel[`IOR_SEL_IDX]];
        `IOR_KIND_INPUT: src_val = inp[sel[`IOR_SEL_IDX]];
        `IOR_KIND_DI: src_val = di[sel[`IOR_SEL_IDX]];
        `IOR_KIND_GPS: src_val = misc[0];
        `IOR_KIND_IRIG: src_val = misc[1];
        `IOR_KIND_CLK10: src_val = misc[2];
        `IOR_KIND_MTIME: src_val = misc[3];
        default: src_val = 1'b0;
      endcase
    end
  endfunction

  // A pin set as an output reads as zero when used as a source
  assign src_inputs = (BIDIR != 0) ? (bidirectional_ext_pin_in & ~pin_dir) : bidirectional_ext_pin_in;
  assign pin_terminate = pin_term;
  assign host_irq = di_pend & di_en;
  assign req_hit = (reg_wr && reg_addr == `IOR_OFS_REQ) ? reg_wdata[LINES-1:0] : {LINES{1'b0}};

  // Control and configuration registers
  always @(posedge ref_clk) begin
    if (rst) begin
      pulse_gen_state <= {LINES{1'b0}};
      pin_dir <= `IOR_RST_DIR;
      pin_term <= `IOR_RST_TERM;
      di_arm <= {LINES{1'b0}};
      di_en <= {LINES{1'b0}};
      err_invalid <= 1'b0;
      for (k = 0; k < LINES; k = k + 1) begin
        out_sel[k] <= {`IOR_KIND_PIG, k[3:0]};
        di_cfg[k] <= `IOR_RST_CFG;
      end
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `IOR_OFS_STATE: pulse_gen_state <= reg_wdata[LINES-1:0];
          `IOR_OFS_SET: pulse_gen_state <= pulse_gen_state | reg_wdata[LINES-1:0];
          `IOR_OFS_CLR: pulse_gen_state <= pulse_gen_state & ~reg_wdata[LINES-1:0];
          `IOR_OFS_ARM: di_arm <= reg_wdata[LINES-1:0];
          `IOR_OFS_EN: di_en <= reg_wdata[LINES-1:0];
          `IOR_OFS_DIR: pin_dir <= reg_wdata[LINES-1:0];
          `IOR_OFS_TERM: pin_term <= reg_wdata[LINES-1:0];
          default: ;
        endcase
        if (reg_addr[7:6] == `IOR_REGION_OUT && reg_addr[1:0] == 2'b00 && idx_ok) begin
          if (sel_ok(reg_wdata[7:0], 1'b0, wr_idx)) begin
            out_sel[wr_idx] <= reg_wdata[7:0];
          end
        end
        if (reg_addr[7:6] == `IOR_REGION_DI && reg_addr[1:0] == 2'b00 && idx_ok) begin
          if (sel_ok(reg_wdata[7:0], 1'b1, wr_idx)) begin
            di_cfg[wr_idx] <= reg_wdata[9:0];
          end
        end
      end
      // Refused selection raises the flag; a new refusal wins over a clear
      if (reg_wr && reg_addr[1:0] == 2'b00 && idx_ok &&
          ((reg_addr[7:6] == `IOR_REGION_OUT && !sel_ok(reg_wdata[7:0], 1'b0, wr_idx)) ||
           (reg_addr[7:6] == `IOR_REGION_DI && !sel_ok(reg_wdata[7:0], 1'b1, wr_idx)))) begin
        err_invalid <= 1'b1;
      end else if (reg_wr && reg_addr == `IOR_OFS_ERR && reg_wdata[0]) begin
        err_invalid <= 1'b0;
      end
    end
  end

  // Per line routing and trigger detection
  genvar g;
  generate
    for (g = 0; g < LINES; g = g + 1) begin : line
      wire out_v = src_val(out_sel[g], rtc_tick, pulse_gen_state, src_inputs, chain_interrupt_line_in,
        {master_time, clk10_signal, irig_signal, gps_pulse});
      wire di_v = src_val(di_cfg[g][7:0], rtc_tick, pulse_gen_state, src_inputs, chain_interrupt_line_in,
        {master_time, clk10_signal, irig_signal, gps_pulse});
      wire out_drive = (out_sel[g][`IOR_SEL_KIND] != `IOR_KIND_NONE) && (BIDIR == 0 || pin_dir[g]);
      reg trig;
      always @* begin
        case (di_cfg[g][`IOR_CFG_MODE])
          `IOR_MODE_RISE: trig = chain_interrupt_line_in[g] & ~di_prev[g];
          `IOR_MODE_FALL: trig = ~chain_interrupt_line_in[g] & di_prev[g];
          `IOR_MODE_HIGH: trig = chain_interrupt_line_in[g] & ~di_pend[g];
          `IOR_MODE_LOW: trig = ~chain_interrupt_line_in[g] & ~di_pend[g];
          default: trig = 1'b0;
        endcase
      end
      // Arming gates capture; a software request counts like a line event
      assign di_fire[g] = di_arm[g] & (trig | req_hit[g]);
      always @(posedge ref_clk) begin
        if (rst) begin
          external_output_line_out[g] <= 1'b0;
          external_output_line_oe[g] <= 1'b0;
          chain_interrupt_line_out[g] <= 1'b0;
          chain_interrupt_line_oe[g] <= 1'b0;
        end else begin
          external_output_line_out[g] <= out_v & out_drive;
          external_output_line_oe[g] <= out_drive;
          chain_interrupt_line_out[g] <= di_v;
          chain_interrupt_line_oe[g] <= (di_cfg[g][`IOR_SEL_KIND] != `IOR_KIND_NONE);
        end
      end
    end
  endgenerate

  // Pending and count requests; a new fire wins over a clear in the same cycle
  always @(posedge ref_clk) begin
    if (rst) begin
      di_prev <= {LINES{1'b0}};
      di_pend <= {LINES{1'b0}};
      fire_todo <= {LINES{1'b0}};
    end else begin
      di_prev <= chain_interrupt_line_in;
      di_pend <= (di_pend & ~pend_clr) | di_fire;
      if (cnt_state == ST_WRITE) begin
        fire_todo <= (fire_todo & ~(12'h001 << cnt_idx)) | di_fire;
      end else begin
        fire_todo <= fire_todo | di_fire;
      end
    end
  end

  // Lowest pending count request
  always @* begin
    next_pick = 4'h0;
    for (j = LINES - 1; j >= 0; j = j - 1) begin
      if (fire_todo[j]) begin
        next_pick = j[3:0];
      end
    end
  end

  // Counter updater: clears memory after reset, then read-modify-write per fire
  always @(posedge ref_clk) begin
    if (rst) begin
      cnt_state <= ST_INIT;
      cnt_idx <= 4'h0;
    end else begin
      case (cnt_state)
        ST_INIT: begin
          if (cnt_idx == LINES - 1) begin
            cnt_state <= ST_IDLE;
            cnt_idx <= 4'h0;
          end else begin
            cnt_idx <= cnt_idx + 4'h1;
          end
        end
        ST_IDLE: begin
          if (|fire_todo) begin
            cnt_idx <= next_pick;
            cnt_state <= ST_READ;
          end
        end
        ST_READ: cnt_state <= ST_WRITE;
        ST_WRITE: cnt_state <= ST_IDLE;
        default: cnt_state <= ST_IDLE;
      endcase
    end
  end

  always @* begin
    mem_we = 1'b0;
    mem_wdata = {CNT_W{1'b0}};
    case (cnt_state)
      ST_INIT: mem_we = 1'b1;
      ST_WRITE: begin
        mem_we = 1'b1;
        mem_wdata = cnt_rdata + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      default: ;
    endcase
  end

  ior_count_mem #(.W(CNT_W), .D(LINES), .AW(4)) u_count_mem (
    .clk(ref_clk), .wr_en(mem_we), .wr_addr(cnt_idx), .wr_data(mem_wdata),
    .rd_a_addr(cnt_idx), .rd_a_data(cnt_rdata), .rd_b_addr(reg_addr[5:2]), .rd_b_data(sw_rdata)
  );

  // Reads answer two cycles after the strobe, so memory and registers share one timing
  always @* begin
    rd_idx = rd_addr_q[5:2];
    next_rdata = 32'h00000000;
    case (rd_addr_q)
      `IOR_OFS_STATE: next_rdata[LINES-1:0] = pulse_gen_state;
      `IOR_OFS_PEND: next_rdata[LINES-1:0] = di_pend;
      `IOR_OFS_ERR: next_rdata[0] = err_invalid;
      `IOR_OFS_ARM: next_rdata[LINES-1:0] = di_arm;
      `IOR_OFS_EN: next_rdata[LINES-1:0] = di_en;
      `IOR_OFS_DIR: next_rdata[LINES-1:0] = pin_dir;
      `IOR_OFS_TERM: next_rdata[LINES-1:0] = pin_term;
      default: begin
        if (rd_addr_q[1:0] == 2'b00 && rd_idx < LINES) begin
          case (rd_addr_q[7:6])
            `IOR_REGION_OUT: next_rdata[7:0] = out_sel[rd_idx];
            `IOR_REGION_DI: next_rdata[9:0] = di_cfg[rd_idx];
            `IOR_REGION_CNT: next_rdata[CNT_W-1:0] = sw_rdata;
            default: next_rdata = 32'h00000000;
          endcase
        end
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      rd_q <= 1'b0;
      rd_addr_q <= 8'h00;
      reg_rdata <= 32'h00000000;
      reg_rvalid <= 1'b0;
    end else begin
      rd_q <= reg_rd;
      rd_addr_q <= reg_addr;
      reg_rvalid <= rd_q;
      if (rd_q) begin
        reg_rdata <= next_rdata;
      end
    end
  end
endmodule // ior_routing
`default_nettype wire

// ===== testbench/ior_far_side.sv
// Far side model: other chained boards and external equipment
`timescale 1ns/1ps
`default_nettype none
module ior_far_side #(
  parameter LINES = 12
) (
  input wire logic [LINES-1:0] chain_interrupt_line_out,
  input wire logic [LINES-1:0] chain_interrupt_line_oe,
  input wire logic [LINES-1:0] far_chain_drv,
  input wire logic [LINES-1:0] far_chain_oe,
  input wire logic [LINES-1:0] external_output_line_out,
  input wire logic [LINES-1:0] external_output_line_oe,
  input wire logic [LINES-1:0] far_pin_drv,
  output wire logic [LINES-1:0] chain_interrupt_line_in,
  output wire logic [LINES-1:0] bidirectional_ext_pin_in
);
  // Pulled-down chain wire; any driver raises it for all boards at once
  assign chain_interrupt_line_in = (chain_interrupt_line_out & chain_interrupt_line_oe) |
    (far_chain_drv & far_chain_oe);
  // Equipment drives only floating pins; levels move on bench command and are held 1 us
  assign bidirectional_ext_pin_in = (external_output_line_out & external_output_line_oe) |
    (far_pin_drv & ~external_output_line_oe);
endmodule // ior_far_side
`default_nettype wire

// ===== testbench/ior_routing_asserts.sv
// Port-level assertion checker for the routing block
`timescale 1ns/1ps
`default_nettype none
module ior_routing_asserts #(
  parameter LINES = 12
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [LINES-1:0] external_output_line_out,
  input wire logic [LINES-1:0] external_output_line_oe,
  input wire logic [LINES-1:0] pin_terminate,
  input wire logic [LINES-1:0] chain_interrupt_line_oe,
  input wire logic [LINES-1:0] host_irq
);
  // Routing untouched since reset; only then outputs 0-5 must follow their own generator bits
  logic dflt;
  logic [LINES-1:0] dir;
  always @(posedge ref_clk) begin
    if (rst) begin
      dflt <= 1'b1;
      dir <= 12'h03F;
    end else if (reg_wr && reg_addr == 8'h24) begin
      dflt <= 1'b0;
      dir <= reg_wdata[LINES-1:0];
    end else if (reg_wr && reg_addr[7:6] == 2'h1) begin
      dflt <= 1'b0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_set;
    reg_wr && reg_addr == 8'h10 && dflt ##2 dflt;
  endsequence
  sequence s_clr;
    reg_wr && reg_addr == 8'h20 && dflt ##2 dflt;
  endsequence
  a_read_latency: assert property (reg_rd |-> ##2 reg_rvalid) else $error("read answer late");
  a_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata)) else $error("read data moved");
  a_set_drives: assert property (s_set |->
    (external_output_line_out[5:0] & $past(reg_wdata[5:0], 2)) == $past(reg_wdata[5:0], 2))
    else $error("set bit not on output");
  a_clr_drops: assert property (s_clr |->
    (external_output_line_out[5:0] & $past(reg_wdata[5:0], 2)) == 6'h00) else $error("cleared bit on output");
  a_reset_quiet: assert property ($fell(rst) |->
    chain_interrupt_line_oe == 0 && host_irq == 0 && pin_terminate == 0) else $error("not quiet after reset");
  a_dflt_oe: assert property ($fell(rst) |-> ##2 external_output_line_oe == 12'h03F)
    else $error("default drive wrong");
  a_oe_dir: assert property ((external_output_line_oe & ~dir & ~$past(dir)) == 0)
    else $error("input pin driven");
  a_term_write: assert property (reg_wr && reg_addr == 8'h28 |=>
    pin_terminate == $past(reg_wdata[LINES-1:0])) else $error("termination not taken");
  a_enable_gate: assert property (reg_wr && reg_addr == 8'h18 && reg_wdata[LINES-1:0] == 0 |=>
    host_irq == 0) else $error("irq while disabled");
endmodule // ior_routing_asserts
bind ior_routing ior_routing_asserts #(.LINES(LINES)) ior_routing_asserts_inst (.ref_clk(ref_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .external_output_line_out(external_output_line_out),
  .external_output_line_oe(external_output_line_oe), .pin_terminate(pin_terminate),
  .chain_interrupt_line_oe(chain_interrupt_line_oe), .host_irq(host_irq));
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for the routing block
`timescale 1ns/1ps
`default_nettype none
`include "ior_defs.vh"
module tb;
  localparam int HOLD = 200; // One microsecond of far-side level
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic [11:0] fc_drv = 12'h000;
  logic [11:0] fc_oe = 12'h000;
  logic [11:0] fp_drv = 12'h000;
  logic [7:0] rtc_lvl = 8'h00;
  logic gps_lvl = 1'b0;
  wire [31:0] reg_rdata;
  wire reg_rvalid;
  wire [11:0] xo, xoe, term, ci, co, coe, irq, pin;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #2.5 ref_clk = ~ref_clk;
  ior_routing ior_routing_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .rtc_tick(rtc_lvl), .gps_pulse(gps_lvl), .irig_signal(1'b0), .clk10_signal(1'b0), .master_time(1'b0),
    .bidirectional_ext_pin_in(pin), .external_output_line_out(xo), .external_output_line_oe(xoe),
    .pin_terminate(term), .chain_interrupt_line_in(ci), .chain_interrupt_line_out(co),
    .chain_interrupt_line_oe(coe), .host_irq(irq));
  ior_far_side ior_far_side_inst (.chain_interrupt_line_out(co), .chain_interrupt_line_oe(coe),
    .far_chain_drv(fc_drv), .far_chain_oe(fc_oe), .external_output_line_out(xo),
    .external_output_line_oe(xoe), .far_pin_drv(fp_drv), .chain_interrupt_line_in(ci),
    .bidirectional_ext_pin_in(pin));
  task automatic print_verdict();
    $display("Checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("Error at %0t: got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic chkv(input logic [11:0] g, input logic [11:0] e);
    chk({20'h0, g}, {20'h0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] g;
    g = 32'hX;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    repeat (4) begin
      if (reg_rvalid === 1'b1) g = reg_rdata;
      @(posedge ref_clk);
      #1;
    end
    chk(g, e);
  endtask
  // One trigger phase: new far level, then pending before and after a clear
  task automatic ps(input logic [11:0] lvl, input logic e0, input logic e1);
    @(posedge ref_clk);
    #1;
    fc_drv = lvl;
    repeat (HOLD) @(posedge ref_clk);
    rd(`IOR_OFS_PEND, {28'h0, e0, 3'h0});
    wr(`IOR_OFS_PEND, 32'h008);
    repeat (4) @(posedge ref_clk);
    rd(`IOR_OFS_PEND, {28'h0, e1, 3'h0});
  endtask
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      print_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    rd(`IOR_OFS_STATE, 32'h0);
    rd(`IOR_OFS_DIR, 32'h03F);
    rd(`IOR_OFS_TERM, 32'h0);
    rd(8'h80, 32'h100);
    chkv(coe, 12'h000);
    chkv(xoe, 12'h03F);
    chkv(term, 12'h000);
    wr(`IOR_OFS_SET, 32'h005);
    wr(`IOR_OFS_SET, 32'hFA0);
    rd(`IOR_OFS_STATE, 32'hFA5);
    chkv(xo & xoe, 12'h025);
    wr(`IOR_OFS_CLR, 32'h0A4);
    rd(`IOR_OFS_STATE, 32'hF01);
    rd(8'h3C, 32'h0);
    wr(8'h58, 32'h036);
    rd(8'h58, 32'h026);
    rd(`IOR_OFS_ERR, 32'h1);
    wr(8'h40, 32'h036);
    repeat (HOLD) @(posedge ref_clk);
    chkv(xo & xoe, 12'h000);
    #1;
    fp_drv = 12'h040;
    repeat (HOLD) @(posedge ref_clk);
    chkv(xo & xoe, 12'h001);
    wr(`IOR_OFS_DIR, 32'h0FF);
    repeat (4) @(posedge ref_clk);
    chkv(xoe, 12'h0FF);
    chkv(xo & xoe, 12'h000);
    wr(`IOR_OFS_TERM, 32'hF0F);
    rd(`IOR_OFS_TERM, 32'hF0F);
    chkv(term, 12'hF0F);
    wr(8'h84, 32'h021);
    wr(`IOR_OFS_ARM, 32'h00E);
    wr(`IOR_OFS_EN, 32'h006);
    chkv(coe, 12'h002);
    chkv(irq, 12'h000);
    wr(`IOR_OFS_SET, 32'h002);
    repeat (HOLD) @(posedge ref_clk);
    chkv(irq, 12'h002);
    chkv(co, 12'h002);
    rd(8'hC4, 32'h1);
    wr(`IOR_OFS_REQ, 32'h004);
    repeat (4) @(posedge ref_clk);
    chkv(irq, 12'h006);
    wr(`IOR_OFS_EN, 32'h000);
    chkv(irq, 12'h000);
    wr(`IOR_OFS_PEND, 32'hFFF);
    fc_oe = 12'h008;
    for (int m = 0; m < 4; m++) begin
      fc_drv = 12'h000;
      wr(8'h8C, {22'h0, m[1:0], 8'h00});
      wr(`IOR_OFS_PEND, 32'h008);
      repeat (HOLD) @(posedge ref_clk);
      ps(12'h008, m != 1, m == 2);
      ps(12'h000, m != 0, m == 3);
    end
    wr(8'h48, 32'h050);
    wr(8'h4C, 32'h013);
    rtc_lvl = 8'h08;
    gps_lvl = 1'b1;
    repeat (4) @(posedge ref_clk);
    chkv(xo & xoe, 12'h00E);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
